/* File: logic/flash_program_erase_timer.sv */
`include "flash_seq_consts.svh"

// Functional notes
// - Word or byte program lasts 30 periods
// - First block location lasts 25 periods
// - Each later block location lasts 18 periods
// - Block end wait of 6 periods
// - Mass erase 10593, segment erase 4819 periods
module flash_program_erase_timer
  import flash_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Timing generator divider setting, periods of sys_clk minus one
  input  wire logic [9:0]  tg_divide,
  // Request side
  input  wire req_t        req,
  input  wire logic        block_last,
  // Status side
  output logic             busy_r,
  output logic             done_r,
  output logic             refused_r,
  // Flash array side
  output array_ctl_t       array_ctl_r
);

  // ****************************************
  // Timing generator tick
  // ****************************************

  logic [9:0]  div_cnt_r;    // Divider down counter
  logic        tg_tick_r;    // One-cycle enable per generator period
  seq_state_t  state_r;      // Sequencer state
  logic [13:0] period_cnt_r; // Periods left in current phase
  logic [5:0]  loc_idx_r;    // Location inside the block
  logic        last_seen_r;  // Host marked the final location
  logic        phase_end;    // Current phase expires this tick

  // Divider makes a one-cycle enable; host picks the ratio so the tick
  // lands inside the allowed generator window.
  // range is host duty
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_r <= `DIV_ZERO;
      tg_tick_r <= 1'b0;
    end
    else if (div_cnt_r == `DIV_ZERO)
    begin
      div_cnt_r <= tg_divide;
      tg_tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r - `DIV_ONE;
      tg_tick_r <= 1'b0;
    end
  end

  assign phase_end = tg_tick_r && (period_cnt_r == `PERIOD_ONE);

  // ****************************************
  // Sequencer
  // ****************************************

  // Main state walk; a phase counts periods down to one then moves on
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r      <= ST_IDLE;
      period_cnt_r <= `PERIOD_ZERO;
      loc_idx_r    <= `BLOCK_INDEX_ZERO;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (req.valid)
          begin
            case (req.op)
              OP_WORD:
              begin
                state_r      <= ST_WORD;
                period_cnt_r <= `WORD_PERIODS;
              end
              OP_BLOCK:
              begin
                state_r      <= ST_BLK_FIRST;
                period_cnt_r <= `BLOCK_FIRST_PERIODS;
                loc_idx_r    <= `BLOCK_INDEX_ZERO;
              end
              OP_SEG_ERASE:
              begin
                state_r      <= ST_ERASE;
                period_cnt_r <= `SEG_ERASE_PERIODS;
              end
              OP_MASS_ERASE:
              begin
                state_r      <= ST_ERASE;
                period_cnt_r <= `MASS_ERASE_PERIODS;
              end
              default:
              begin
                state_r <= ST_IDLE;
              end
            endcase
          end
        end
        ST_BLK_FIRST, ST_BLK_NEXT:
        begin
          if (tg_tick_r)
          begin
            period_cnt_r <= period_cnt_r - `PERIOD_ONE;
          end
          if (phase_end)
          begin
            // Block stops at the last index or when the host marks it; the live
            // mark is read too, so a mark in the closing cycle is not lost
            if (last_seen_r || block_last || loc_idx_r == `BLOCK_LAST_INDEX)
            begin
              state_r      <= ST_BLK_END;
              period_cnt_r <= `BLOCK_END_PERIODS;
            end
            else
            begin
              state_r      <= ST_BLK_NEXT;
              period_cnt_r <= `BLOCK_NEXT_PERIODS;
              loc_idx_r    <= loc_idx_r + `BLOCK_INDEX_ONE;
            end
          end
        end
        ST_WORD, ST_BLK_END, ST_ERASE:
        begin
          if (tg_tick_r)
          begin
            period_cnt_r <= period_cnt_r - `PERIOD_ONE;
          end
          if (phase_end)
          begin
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Latch the host's final-location mark for the current block
  // host bounds block time
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_seen_r <= 1'b0;
    end
    else if (state_r == ST_IDLE)
    begin
      last_seen_r <= 1'b0;
    end
    else if (block_last)
    begin
      last_seen_r <= 1'b1;
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************

  // Busy from request acceptance until the final phase expires
  // busy and refusal
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      done_r    <= phase_end &&
                   (state_r == ST_WORD || state_r == ST_BLK_END || state_r == ST_ERASE);
      refused_r <= req.valid && (state_r != ST_IDLE);
      if (state_r == ST_IDLE)
      begin
        busy_r <= req.valid && (req.op != OP_NONE) &&
                  (req.op == OP_WORD || req.op == OP_BLOCK ||
                   req.op == OP_SEG_ERASE || req.op == OP_MASS_ERASE);
      end
      else if (phase_end && state_r != ST_BLK_FIRST && state_r != ST_BLK_NEXT)
      begin
        busy_r <= 1'b0;
      end
    end
  end

  // Array strobes follow the state; the step pulse marks the end of each location
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      array_ctl_r <= '0;
    end
    else
    begin
      array_ctl_r.program_en    <= (state_r == ST_WORD) || (state_r == ST_BLK_FIRST) ||
                                   (state_r == ST_BLK_NEXT);
      array_ctl_r.erase_en      <= (state_r == ST_ERASE);
      array_ctl_r.mass_en       <= (state_r == ST_ERASE) &&
                                   (period_cnt_r > `SEG_ERASE_PERIODS ||
                                    array_ctl_r.mass_en);
      array_ctl_r.location_step <= phase_end &&
                                   (state_r == ST_BLK_FIRST || state_r == ST_BLK_NEXT);
    end
  end

endmodule : flash_program_erase_timer

/* File: logic/flash_seq_consts.svh */
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// ****************************************
// Phase lengths in timing-generator periods
// ****************************************
`define WORD_PERIODS        14'h001e
`define BLOCK_FIRST_PERIODS 14'h0019
`define BLOCK_NEXT_PERIODS  14'h0012
`define BLOCK_END_PERIODS   14'h0006
`define MASS_ERASE_PERIODS  14'h2961
`define SEG_ERASE_PERIODS   14'h12d3
`define PERIOD_ONE          14'h0001
`define PERIOD_ZERO         14'h0000

// ****************************************
// Divider and block geometry
// ****************************************
`define DIV_ZERO            10'h000
`define DIV_ONE             10'h001
`define BLOCK_LAST_INDEX    6'h3f
`define BLOCK_INDEX_ZERO    6'h00
`define BLOCK_INDEX_ONE     6'h01

`endif

/* File: logic/flash_seq_pkg.sv */
package flash_seq_pkg;

  // ****************************************
  // Operation codes requested by software
  // ****************************************
  typedef enum logic [2:0]
  {
    OP_NONE       = 3'h0,
    OP_WORD       = 3'h1,
    OP_BLOCK      = 3'h2,
    OP_SEG_ERASE  = 3'h3,
    OP_MASS_ERASE = 3'h4
  } op_t;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0]
  {
    ST_IDLE       = 3'h0,
    ST_WORD       = 3'h1,
    ST_BLK_FIRST  = 3'h2,
    ST_BLK_NEXT   = 3'h3,
    ST_BLK_END    = 3'h4,
    ST_ERASE      = 3'h5
  } seq_state_t;

  // Request bundle from the controlling party
  typedef struct packed
  {
    logic valid;
    op_t  op;
  } req_t;

  // Strobes toward the flash array
  typedef struct packed
  {
    logic program_en;
    logic erase_en;
    logic mass_en;
    logic location_step;
  } array_ctl_t;

endpackage : flash_seq_pkg

/* File: sim/flash_array_model.sv */
module flash_array_model
  import flash_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Array strobes
  input  wire array_ctl_t ctl,
  output int              steps
);
  timeunit 1ns;
  timeprecision 1ps;
  // Locations written; cleared once no write runs
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      steps <= 0;
    else if (ctl.location_step)
      steps <= steps + 1;
    else if (!ctl.program_en)
      steps <= 0;
endmodule : flash_array_model

/* File: sim/flash_program_erase_timer_chk.sv */
module flash_program_erase_timer_chk
  import flash_seq_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [9:0] tg_divide,
  input wire req_t       req,
  input wire logic       block_last,
  input wire logic       busy_r,
  input wire logic       done_r,
  input wire logic       refused_r,
  input wire array_ctl_t array_ctl_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [2:0]  op_d;
  logic [2:0]  op_r;
  logic [15:0] cnt;
  // Job code and busy length; lengths only hold at divide zero
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      op_d <= 3'h0;
      op_r <= 3'h0;
      cnt  <= 16'h0000;
    end
    else
    begin
      op_d <= req.op;
      op_r <= $rose(busy_r) ? op_d : op_r;
      cnt  <= $rose(busy_r) ? 16'h0001 : cnt + 16'(busy_r);
    end
  start_a: assert property ($rose(busy_r) |-> $past(req.valid && req.op inside {[1:4]}))
    else $error("busy rose without a valid request");
  bad_op_a: assert property (req.valid && !busy_r && !$past(req.valid) &&
    !(req.op inside {[1:4]}) |=> !busy_r) else $error("bad code started a job");
  refuse_a: assert property (refused_r |-> $past(req.valid))
    else $error("refusal without a request");
  done_end_a: assert property ($fell(busy_r) |-> done_r && $past(busy_r))
    else $error("busy ended without done");
  word_len_a: assert property (done_r && op_r == OP_WORD && tg_divide == 10'h000 |->
    cnt inside {[30:32]}) else $error("word length wrong");
  seg_len_a: assert property (done_r && op_r == OP_SEG_ERASE &&
    tg_divide == 10'h000 |-> cnt inside {[4819:4821]}) else $error("segment erase length wrong");
  mass_len_a: assert property (done_r && op_r == OP_MASS_ERASE &&
    tg_divide == 10'h000 |-> cnt inside {[10593:10595]}) else $error("mass erase length wrong");
  step_blk_a: assert property (array_ctl_r.location_step |-> op_r == OP_BLOCK)
    else $error("location step outside a block");
  // Strobes lag busy by one cycle, so both busy samples must be high
  prog_en_a: assert property (busy_r && $past(busy_r) && op_r == OP_WORD |->
    array_ctl_r.program_en && !array_ctl_r.erase_en) else $error("word without program strobe");
  mass_sel_a: assert property (busy_r && $past(busy_r) &&
    op_r inside {OP_SEG_ERASE, OP_MASS_ERASE} |-> array_ctl_r.erase_en &&
    !array_ctl_r.program_en && (array_ctl_r.mass_en == (op_r == OP_MASS_ERASE)))
    else $error("erase strobes wrong for the job");
  idle_quiet_a: assert property (!$past(busy_r) |->
    !array_ctl_r.program_en && !array_ctl_r.erase_en) else $error("array strobe while idle");
  c_word: cover property (done_r && op_r == OP_WORD);
  c_step: cover property (array_ctl_r.location_step);
  c_ref: cover property (refused_r);
  c_mass: cover property (done_r && op_r == OP_MASS_ERASE);
endmodule : flash_program_erase_timer_chk

bind flash_program_erase_timer flash_program_erase_timer_chk chk_u
(
  .sys_clk     (sys_clk),
  .rstn        (rstn),
  .tg_divide   (tg_divide),
  .req         (req),
  .block_last  (block_last),
  .busy_r      (busy_r),
  .done_r      (done_r),
  .refused_r   (refused_r),
  .array_ctl_r (array_ctl_r)
);

/* File: sim/flash_program_erase_timer_tb.sv */
module flash_program_erase_timer_tb
  import flash_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {op_t op; int locs; int n;} row_t;
  logic       sys_clk = 0, rstn = 0, block_last = 0, busy_r, done_r, refused_r;
  logic [9:0] tg_divide = 10'h000;
  req_t       req = '0;
  array_ctl_t array_ctl_r;
  int         steps, mismatches, n_tests, b, s;
  // Ordinary jobs: code, block locations, nominal periods
  // block totals stay short
  row_t rows [6] = '{'{OP_WORD, 0, 30}, '{OP_SEG_ERASE, 0, 4819}, '{OP_MASS_ERASE, 0, 10593},
    '{OP_BLOCK, 1, 31}, '{OP_BLOCK, 3, 67}, '{OP_BLOCK, 64, 1165}};
  always #2.5 sys_clk = ~sys_clk;
  flash_program_erase_timer dut_u (.sys_clk, .rstn, .tg_divide, .req, .block_last,
    .busy_r, .done_r, .refused_r, .array_ctl_r);
  flash_array_model far_u (.sys_clk, .rstn, .ctl(array_ctl_r), .steps);
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // Range compare; an unknown never passes
  task automatic chk(string nm, int lo, int hi, logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      mismatches++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk
  // One job; a second request lands at busy count hit to be refused
  task automatic run(op_t op, int locs, int hit, int lim, output int bc, output int sc);
    bc = 0;
    sc = 0;
    req = '{1'b1, op};
    repeat (lim)
    begin
      @(negedge sys_clk);
      if (bc == hit + 1)
        chk("refused", 1, 1, refused_r);
      req = '{bc == hit, OP_WORD};
      block_last = (steps == locs - 1);
      bc += busy_r;
      // The model clears its count once the strobe drops, so keep the peak
      sc = (steps > sc) ? steps : sc;
      if (done_r === 1'b1)
        break;
    end
    if (done_r !== 1'b1)
    begin
      mismatches++;
      results();
    end
  endtask : run
  initial
  begin
    repeat (2) @(negedge sys_clk);
    chk("reset outs", 0, 0, {busy_r, done_r, refused_r, array_ctl_r});
    rstn = 1;
    foreach (rows[i])
    begin
      run(rows[i].op, rows[i].locs, -5, 12000, b, s);
      chk("busy", rows[i].n, rows[i].n + 2, b);
      chk("steps", rows[i].locs, rows[i].locs, s);
    end
    run(OP_WORD, 0, 4, 40, b, s);
    chk("busy", 30, 32, b);
    req = '{1'b1, op_t'(3'h5)};
    @(negedge sys_clk) req = '0;
    @(negedge sys_clk) chk("bad op", 0, 0, busy_r);
    // Slower generator; first tick may come up to one period early
    // 513 clocks, about 390 kHz
    tg_divide = 10'h200;
    run(OP_WORD, 0, -5, 16000, b, s);
    chk("slow word", 29 * 513 + 1, 30 * 513 + 2, b);
    req = '{1'b1, OP_SEG_ERASE};
    repeat (50) @(negedge sys_clk) req = '0;
    rstn = 0;
    @(negedge sys_clk) chk("mid reset", 0, 0, {busy_r, done_r, refused_r, array_ctl_r});
    tg_divide = 10'h000;
    rstn = 1;
    // A job taken at the first edge after release must run in full
    run(OP_WORD, 0, -5, 40, b, s);
    chk("word after reset", 30, 32, b);
    results();
  end
endmodule : flash_program_erase_timer_tb
